// [core/pag_main.v]
// Parameter access guard: write protect, direction limit, view filter and password lock.
// Assumes a parameter store answering store_rdata combinationally for req_param.
// Summary of operation
// - Protect 2 allows other writes in any state
// - Protect 2 blocks run-sensitive writes while running
// - Direction limit 0 both, 1 no reverse, 2 no forward
// - Direction limit applies to every start source
// - Extended view 9999 simple only, 0 all
// - Network reads ignore view unless source is 2
// - Lock parameters need view 0, password excepted
// - Lock level gates panel and network separately
// - View filter and write protect still apply
// - Password is 1000 to 9998 after level set
// - Password write refused while level is 9999
// - Registered password enforces level until unlock
// - Password read returns 0 to 5 once registered
// - Levels 101-106 show error count, others not
// - Correct password unlocks, wrong one counts error
// - Five errors at 101-106 block unlocking
// - All clear while stopped, protect not 1, releases lock and resets settings
// - Self updates pass despite password lock
// - Lock-refused access gives locked indication
// - Contrast stays accessible with parameter unit
// - Level and password reset 9999, level range checked
// - Protect 0 allows writes only while stopped, write protect itself excepted
// - Protect 1 blocks writes except a small set
`timescale 1ns/1ps
`include "pag_defs.vh"
module pag_main (
    input  wire        clk_sys,
    input  wire        reset,
    input  wire        req_valid,
    input  wire        req_source,
    input  wire        req_write,
    input  wire [15:0] req_param,
    input  wire [15:0] req_wdata,
    input  wire        req_simple,
    input  wire        unit_attached,
    input  wire        motor_running,
    input  wire [15:0] store_rdata,
    input  wire        all_clear_req,
    input  wire        self_wr_valid,
    input  wire [15:0] self_wr_param,
    input  wire [15:0] self_wr_data,
    input  wire        forward_start,
    input  wire        reverse_start,
    input  wire        panel_fwd,
    input  wire        panel_rev,
    input  wire        net_fwd,
    input  wire        net_rev,
    output reg         rsp_valid,
    output reg         rsp_ok,
    output reg         rsp_locked,
    output reg  [15:0] rsp_rdata,
    output reg         store_wr,
    output reg  [15:0] store_param,
    output reg  [15:0] store_wdata,
    output reg         self_store_wr,
    output reg  [15:0] self_store_param,
    output reg  [15:0] self_store_wdata,
    output reg         store_clear,
    output reg         run_fwd,
    output reg         run_rev,
    output reg         lock_active
);
    reg  [15:0] write_protect_select_r;
    reg  [15:0] direction_limit_r;
    reg  [15:0] extended_view_select_r;
    reg  [15:0] lock_level_r;
    reg  [15:0] command_source_select_r;
    reg  [15:0] pw_value_r;
    reg         pw_reg_r;
    reg  [2:0]  err_cnt_r;
    wire        fwd_pin;
    wire        rev_pin;
    wire        lvl_rd_ok;
    wire        lvl_wr_ok;

    reg         view_block;
    reg         wp_block;
    reg         lock_exempt;
    reg         rd_lock_ok;
    reg         wr_lock_ok;
    reg         hi_level;
    reg         fwd_any;
    reg         rev_any;
    reg         clear_go;

    pag_sync3 u_sync_fwd (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (forward_start),
        .level_out (fwd_pin)
    );

    pag_sync3 u_sync_rev (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .pin_in    (reverse_start),
        .level_out (rev_pin)
    );

    pag_lock_decode u_lock (
        .lock_level (lock_level_r),
        .source     (req_source),
        .rd_ok      (lvl_rd_ok),
        .wr_ok      (lvl_wr_ok)
    );

    function run_sensitive;
        input [15:0] pn;
        begin
            run_sensitive = (pn == `PAG_PN_OP_MODE) || (pn == `PAG_PN_AUTO_TUNE) ||
                (pn >= `PAG_PN_IN_TERM_LO && pn <= `PAG_PN_IN_TERM_HI) ||
                (pn >= `PAG_PN_LIFE_LO && pn <= `PAG_PN_LIFE_HI) ||
                (pn == `PAG_PN_RS_23) || (pn == `PAG_PN_RS_40) || (pn == `PAG_PN_RS_48) ||
                (pn == `PAG_PN_RS_60) || (pn == `PAG_PN_RS_66) || (pn == `PAG_PN_RS_71) ||
                (pn == `PAG_PN_RS_80) || (pn == `PAG_PN_RS_82) || (pn == `PAG_PN_RS_83) ||
                (pn == `PAG_PN_RS_84) || (pn == `PAG_PN_RS_90) || (pn == `PAG_PN_RS_190) ||
                (pn == `PAG_PN_RS_192) || (pn == `PAG_PN_RS_261) || (pn == `PAG_PN_RS_298) ||
                (pn == `PAG_PN_RS_343) || (pn == `PAG_PN_RS_450) || (pn == `PAG_PN_RS_561) ||
                (pn == `PAG_PN_RS_563) || (pn == `PAG_PN_RS_564);
        end
    endfunction

    function protect1_allowed;
        input [15:0] pn;
        begin
            protect1_allowed = (pn == `PAG_PN_STALL_LEVEL) || (pn == `PAG_PN_RESET_SEL) ||
                (pn == `PAG_PN_WRITE_PROTECT) || (pn == `PAG_PN_OP_MODE) ||
                (pn == `PAG_PN_EXT_VIEW) || (pn == `PAG_PN_LOCK_LEVEL) ||
                (pn == `PAG_PN_PASSWORD);
        end
    endfunction

    function level_legal;
        input [15:0] v;
        begin
            level_legal = (v >= `PAG_VAL_ONE && v <= `PAG_VAL_LVL_LO_MAX) ||
                (v >= `PAG_VAL_LVL_HI_MIN && v <= `PAG_VAL_LVL_HI_MAX) || (v == `PAG_VAL_NONE);
        end
    endfunction

    // Access classification of the current request
    always @* begin
        hi_level = (lock_level_r >= `PAG_VAL_LVL_HI_MIN) && (lock_level_r <= `PAG_VAL_LVL_HI_MAX);
        view_block = 1'b0;
        if (extended_view_select_r != `PAG_VAL_ZERO && !req_simple) begin
            view_block = 1'b1;
        end
        if (req_source == `PAG_SRC_NETWORK && !req_write &&
            command_source_select_r != `PAG_VAL_TWO) begin
            view_block = 1'b0;
        end
        if ((req_param == `PAG_PN_LOCK_LEVEL || req_param == `PAG_PN_PASSWORD) &&
            req_write && extended_view_select_r != `PAG_VAL_ZERO) begin
            view_block = 1'b1;
        end
        // password stays writable under lock level
        if (req_param == `PAG_PN_PASSWORD && req_write && lock_level_r != `PAG_VAL_NONE) begin
            view_block = 1'b0;
        end
        if (req_param == `PAG_PN_CONTRAST && unit_attached) begin
            view_block = 1'b0;
        end
        wp_block = 1'b0;
        // protect 0 writes only at stop, except write protect itself
        if (write_protect_select_r == `PAG_VAL_ZERO) begin
            wp_block = motor_running && (req_param != `PAG_PN_WRITE_PROTECT);
        end
        if (write_protect_select_r == `PAG_VAL_ONE) begin
            wp_block = !protect1_allowed(req_param);
        end
        if (write_protect_select_r == `PAG_VAL_TWO) begin
            wp_block = motor_running && run_sensitive(req_param);
        end
        lock_exempt = (req_param == `PAG_PN_LOCK_LEVEL) || (req_param == `PAG_PN_PASSWORD) ||
            ((req_param == `PAG_PN_CONTRAST) && unit_attached);
        rd_lock_ok = !pw_reg_r || lvl_rd_ok || lock_exempt;
        wr_lock_ok = !pw_reg_r || lvl_wr_ok || lock_exempt;
        fwd_any = panel_fwd || net_fwd || fwd_pin;
        rev_any = panel_rev || net_rev || rev_pin;
        clear_go = all_clear_req && !motor_running && (write_protect_select_r != `PAG_VAL_ONE);
    end

    always @(posedge clk_sys) begin
        if (reset) begin
            write_protect_select_r  <= `PAG_RST_WRITE_PROTECT;
            direction_limit_r       <= `PAG_RST_DIR_LIMIT;
            extended_view_select_r  <= `PAG_RST_EXT_VIEW;
            lock_level_r            <= `PAG_RST_LOCK_LEVEL;
            command_source_select_r <= `PAG_RST_CMD_SOURCE;
            pw_value_r              <= `PAG_VAL_NONE;
            pw_reg_r                <= 1'b0;
            err_cnt_r               <= 3'h0;
            rsp_valid               <= 1'b0;
            rsp_ok                  <= 1'b0;
            rsp_locked              <= 1'b0;
            rsp_rdata               <= 16'h0000;
            store_wr                <= 1'b0;
            store_param             <= 16'h0000;
            store_wdata             <= 16'h0000;
            self_store_wr           <= 1'b0;
            self_store_param        <= 16'h0000;
            self_store_wdata        <= 16'h0000;
            store_clear             <= 1'b0;
            run_fwd                 <= 1'b0;
            run_rev                 <= 1'b0;
            lock_active             <= 1'b0;
        end else begin
            rsp_valid     <= 1'b0;
            rsp_ok        <= 1'b0;
            rsp_locked    <= 1'b0;
            store_wr      <= 1'b0;
            store_clear   <= 1'b0;
            self_store_wr    <= self_wr_valid;
            self_store_param <= self_wr_param;
            self_store_wdata <= self_wr_data;
            run_fwd <= fwd_any && !rev_any && (direction_limit_r != `PAG_VAL_TWO);
            run_rev <= rev_any && !fwd_any && (direction_limit_r != `PAG_VAL_ONE);
            lock_active <= pw_reg_r;
            if (clear_go) begin
                write_protect_select_r  <= `PAG_RST_WRITE_PROTECT;
                direction_limit_r       <= `PAG_RST_DIR_LIMIT;
                extended_view_select_r  <= `PAG_RST_EXT_VIEW;
                lock_level_r            <= `PAG_RST_LOCK_LEVEL;
                command_source_select_r <= `PAG_RST_CMD_SOURCE;
                pw_value_r              <= `PAG_VAL_NONE;
                pw_reg_r                <= 1'b0;
                err_cnt_r               <= 3'h0;
                store_clear             <= 1'b1;
                lock_active             <= 1'b0;
            end else if (req_valid) begin
                rsp_valid <= 1'b1;
                rsp_rdata <= store_rdata;
                if (!req_write) begin
                    if (!rd_lock_ok) begin
                        rsp_locked <= 1'b1;
                        rsp_rdata  <= 16'h0000;
                    end else if (view_block) begin
                        rsp_rdata  <= 16'h0000;
                    end else begin
                        rsp_ok <= 1'b1;
                        case (req_param)
                            `PAG_PN_WRITE_PROTECT: rsp_rdata <= write_protect_select_r;
                            `PAG_PN_DIR_LIMIT:     rsp_rdata <= direction_limit_r;
                            `PAG_PN_EXT_VIEW:      rsp_rdata <= extended_view_select_r;
                            `PAG_PN_LOCK_LEVEL:    rsp_rdata <= lock_level_r;
                            `PAG_PN_CMD_SOURCE:    rsp_rdata <= command_source_select_r;
                            `PAG_PN_PASSWORD: begin
                                if (!pw_reg_r) begin
                                    rsp_rdata <= `PAG_VAL_NONE;
                                end else if (hi_level) begin
                                    rsp_rdata <= {13'h0000, err_cnt_r};
                                end else begin
                                    rsp_rdata <= 16'h0000;
                                end
                            end
                            default: rsp_rdata <= store_rdata;
                        endcase
                    end
                end else if (!wr_lock_ok) begin
                    rsp_locked <= 1'b1;
                end else if (!view_block && !wp_block) begin
                    case (req_param)
                        `PAG_PN_WRITE_PROTECT: begin
                            if (req_wdata <= `PAG_VAL_TWO) begin
                                write_protect_select_r <= req_wdata;
                                rsp_ok <= 1'b1;
                            end
                        end
                        `PAG_PN_DIR_LIMIT: begin
                            if (req_wdata <= `PAG_VAL_TWO) begin
                                direction_limit_r <= req_wdata;
                                rsp_ok <= 1'b1;
                            end
                        end
                        `PAG_PN_EXT_VIEW: begin
                            if (req_wdata == `PAG_VAL_ZERO || req_wdata == `PAG_VAL_NONE) begin
                                extended_view_select_r <= req_wdata;
                                rsp_ok <= 1'b1;
                            end
                        end
                        `PAG_PN_CMD_SOURCE: begin
                            command_source_select_r <= req_wdata;
                            rsp_ok <= 1'b1;
                        end
                        `PAG_PN_LOCK_LEVEL: begin
                            if (!pw_reg_r && level_legal(req_wdata)) begin
                                lock_level_r <= req_wdata;
                                rsp_ok <= 1'b1;
                            end
                        end
                        `PAG_PN_PASSWORD: begin
                            if (lock_level_r == `PAG_VAL_NONE) begin
                                rsp_ok <= 1'b0;
                            end else if (!pw_reg_r) begin
                                if (req_wdata >= `PAG_VAL_PW_MIN && req_wdata <= `PAG_VAL_PW_MAX) begin
                                    pw_value_r <= req_wdata;
                                    pw_reg_r   <= 1'b1;
                                    rsp_ok     <= 1'b1;
                                end
                            end else if (hi_level && err_cnt_r == `PAG_ERR_MAX) begin
                                rsp_locked <= 1'b1;
                            end else if (req_wdata == pw_value_r) begin
                                pw_reg_r   <= 1'b0;
                                pw_value_r <= `PAG_VAL_NONE;
                                err_cnt_r  <= 3'h0;
                                rsp_ok     <= 1'b1;
                            end else begin
                                rsp_locked <= 1'b1;
                                if (err_cnt_r != `PAG_ERR_MAX) begin
                                    err_cnt_r <= err_cnt_r + 3'h1;
                                end
                            end
                        end
                        default: begin
                            store_wr    <= 1'b1;
                            store_param <= req_param;
                            store_wdata <= req_wdata;
                            rsp_ok      <= 1'b1;
                        end
                    endcase
                end
            end
        end
    end
endmodule

// [core/pag_defs.vh]
// Constants for the parameter access guard: parameter numbers, codes, reset values.
// Assumes parameter numbers and values travel as 16-bit binary words.
`ifndef PAG_DEFS_VH
`define PAG_DEFS_VH

// Parameter numbers held or checked by the guard
`define PAG_PN_STALL_LEVEL     16'h0016
`define PAG_PN_RESET_SEL       16'h004B
`define PAG_PN_WRITE_PROTECT   16'h004D
`define PAG_PN_DIR_LIMIT       16'h004E
`define PAG_PN_OP_MODE         16'h004F
`define PAG_PN_AUTO_TUNE       16'h0060
`define PAG_PN_EXT_VIEW        16'h00A0
`define PAG_PN_LOCK_LEVEL      16'h0128
`define PAG_PN_PASSWORD        16'h0129
`define PAG_PN_CMD_SOURCE      16'h0227
`define PAG_PN_CONTRAST        16'h03DF

// Run-sensitive ranges and singles
`define PAG_PN_IN_TERM_LO      16'h00B2
`define PAG_PN_IN_TERM_HI      16'h00B6
`define PAG_PN_LIFE_LO         16'h00FF
`define PAG_PN_LIFE_HI         16'h0102
`define PAG_PN_RS_23           16'h0017
`define PAG_PN_RS_40           16'h0028
`define PAG_PN_RS_48           16'h0030
`define PAG_PN_RS_60           16'h003C
`define PAG_PN_RS_66           16'h0042
`define PAG_PN_RS_71           16'h0047
`define PAG_PN_RS_80           16'h0050
`define PAG_PN_RS_82           16'h0052
`define PAG_PN_RS_83           16'h0053
`define PAG_PN_RS_84           16'h0054
`define PAG_PN_RS_90           16'h005A
`define PAG_PN_RS_190          16'h00BE
`define PAG_PN_RS_192          16'h00C0
`define PAG_PN_RS_261          16'h0105
`define PAG_PN_RS_298          16'h012A
`define PAG_PN_RS_343          16'h0157
`define PAG_PN_RS_450          16'h01C2
`define PAG_PN_RS_561          16'h0231
`define PAG_PN_RS_563          16'h0233
`define PAG_PN_RS_564          16'h0234

// Values
`define PAG_VAL_NONE           16'h270F
`define PAG_VAL_PW_MIN         16'h03E8
`define PAG_VAL_PW_MAX         16'h270E
`define PAG_VAL_ZERO           16'h0000
`define PAG_VAL_ONE            16'h0001
`define PAG_VAL_TWO            16'h0002
`define PAG_VAL_LVL_LO_MAX     16'h0006
`define PAG_VAL_LVL_HI_MIN     16'h0065
`define PAG_VAL_LVL_HI_MAX     16'h006A
`define PAG_VAL_LVL_HI_OFS     16'h0064
`define PAG_ERR_MAX            3'h5

// Reset values
`define PAG_RST_WRITE_PROTECT  16'h0000
`define PAG_RST_DIR_LIMIT      16'h0000
`define PAG_RST_EXT_VIEW       16'h270F
`define PAG_RST_LOCK_LEVEL     16'h270F
`define PAG_RST_CMD_SOURCE     16'h270F

// Command source codes
`define PAG_SRC_PANEL          1'b0
`define PAG_SRC_NETWORK        1'b1

`endif

// [core/pag_sync3.v]
// Three-stage synchroniser for a pin input; output changes once stages two and three agree.
// Assumes the pin is asynchronous to clk_sys.
`timescale 1ns/1ps
module pag_sync3 (
    input  wire clk_sys,
    input  wire reset,
    input  wire pin_in,
    output reg  level_out
);
    reg s1_r;
    reg s2_r;
    reg s3_r;

    always @(posedge clk_sys) begin
        if (reset) begin
            s1_r      <= 1'b0;
            s2_r      <= 1'b0;
            s3_r      <= 1'b0;
            level_out <= 1'b0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule

// [core/pag_lock_decode.v]
// Decodes the lock level into read and write permission for one command source.
// Assumes lock_level already holds a legal value.
`timescale 1ns/1ps
`include "pag_defs.vh"
module pag_lock_decode (
    input  wire [15:0] lock_level,
    input  wire        source,
    output reg         rd_ok,
    output reg         wr_ok
);
    reg [15:0] base;

    always @* begin
        base = lock_level;
        if (lock_level >= `PAG_VAL_LVL_HI_MIN && lock_level <= `PAG_VAL_LVL_HI_MAX) begin
            base = lock_level - `PAG_VAL_LVL_HI_OFS;
        end
        rd_ok = 1'b1;
        wr_ok = 1'b1;
        case (base[2:0])
            3'h1: begin
                wr_ok = 1'b0;
            end
            3'h2: begin
                wr_ok = (source == `PAG_SRC_NETWORK);
            end
            3'h3: begin
                wr_ok = (source == `PAG_SRC_PANEL);
            end
            3'h4: begin
                rd_ok = 1'b0;
                wr_ok = 1'b0;
            end
            3'h5: begin
                rd_ok = (source == `PAG_SRC_NETWORK);
                wr_ok = (source == `PAG_SRC_NETWORK);
            end
            3'h6: begin
                rd_ok = (source == `PAG_SRC_PANEL);
                wr_ok = (source == `PAG_SRC_PANEL);
            end
            default: begin
                rd_ok = 1'b1;
                wr_ok = 1'b1;
            end
        endcase
        if (lock_level == `PAG_VAL_NONE) begin
            rd_ok = 1'b1;
            wr_ok = 1'b1;
        end
    end
endmodule

// [bench/pag_store_model.sv]
// Parameter store model behind the guard.
// Assumes one-cycle write and clear pulses.
`timescale 1ns/1ps
module pag_store_model (
    input  wire        clk_sys, store_wr, store_clear,
    input  wire [15:0] store_param, store_wdata, req_param,
    output wire [15:0] store_rdata,
    output wire        req_simple
);
    logic [15:0] mem [0:1023];
    initial for (int i = 0; i < 1024; i++) mem[i] = 16'(i);
    always @(posedge clk_sys)
        if (store_clear) for (int i = 0; i < 1024; i++) mem[i] <= 16'(i);
        else if (store_wr) mem[store_param[9:0]] <= store_wdata;
    assign store_rdata = mem[req_param[9:0]];
    assign req_simple = req_param <= 16'h00A0;
endmodule

// [bench/pag_sva.sv]
// Port checker for the parameter access guard.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module pag_sva (
    input wire clk_sys, reset, req_valid, req_write, motor_running, all_clear_req, self_wr_valid,
    input wire rsp_valid, rsp_ok, rsp_locked, store_wr, self_store_wr, store_clear, run_fwd, run_rev,
    input wire [15:0] req_param, self_wr_param, self_store_param, rsp_rdata, self_wr_data, self_store_wdata
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    chk_rsp_follows: assert property (req_valid && !all_clear_req |=> rsp_valid) else $error("no answer");
    chk_lock_refuses: assert property (rsp_valid && rsp_locked |-> !rsp_ok) else $error("locked done");
    chk_dir_excl: assert property (!(run_fwd && run_rev)) else $error("both ways");
    chk_self_pass: assert property (self_wr_valid |=> self_store_wr && self_store_param == $past(self_wr_param)
        && self_store_wdata == $past(self_wr_data)) else $error("self lost");
    chk_clear_cause: assert property (store_clear |-> $past(all_clear_req) && !$past(motor_running))
        else $error("bad clear");
    chk_tune_run: assert property (req_valid && req_write && motor_running
        && req_param == 16'h0060 |=> !store_wr) else $error("tune written");
    chk_store_cause: assert property (store_wr |-> $past(req_valid && req_write) && rsp_ok) else $error("stray");
    chk_refused_zero: assert property (rsp_valid && !rsp_ok && !$past(req_write) |-> rsp_rdata == 16'h0000)
        else $error("read data");
endmodule

// [bench/pag_main_tb.sv]
// Self-checking bench for the parameter access guard.
// Assumes the store model answers reads at once.
`timescale 1ns/1ps
module pag_main_tb;
    logic clk_sys = 0, reset = 1, req_valid = 0, req_source = 0, req_write = 0, unit_attached = 1;
    logic motor_running = 0, all_clear_req = 0, self_wr_valid = 0, forward_start = 0, reverse_start = 0;
    logic panel_fwd = 0, panel_rev = 0, net_fwd = 0, net_rev = 0, req_simple, rsp_valid, rsp_ok, rsp_locked;
    logic store_wr, self_store_wr, store_clear, run_fwd, run_rev, lock_active, f, r;
    logic [15:0] req_param = 0, req_wdata = 0, self_wr_param = 0, self_wr_data = 0, store_rdata, rsp_rdata, w;
    logic [15:0] store_param, store_wdata, self_store_param, self_store_wdata;
    int fail_count = 0, n_tests = 0, i;
    pag_main u_dut (.*);
    pag_store_model u_store (.*);
    always #5 clk_sys = ~clk_sys;
    function logic dir(input logic a, b, en); return a && !b && en; endfunction
    task chk(input logic [15:0] got, exp);
        n_tests++;
        if (got !== exp) fail_count++;
        if (got !== exp) $display("BAD %0t got %h exp %h", $time, got, exp);
    endtask
    task test_done;
        if (fail_count == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task acc(input logic s, wr, input logic [15:0] p, d, input logic ok, lk, input logic [15:0] rd);
        @(negedge clk_sys);
        {req_valid, req_source, req_write, req_param, req_wdata} = {1'b1, s, wr, p, d};
        @(negedge clk_sys);
        req_valid = 0;
        chk({rsp_valid, rsp_ok, rsp_locked}, {1'b1, ok, lk});
        if (!wr) chk(rsp_rdata, rd);
    endtask
    initial begin
        void'($urandom(32'h46993dbc));
        repeat (12) @(negedge clk_sys);
        reset = 0;
        acc(0,0,16'h0200,0,0,0,0);
        acc(1,0,16'h0200,0,1,0,16'h0200);
        acc(1,1,16'h0129,16'h04D2,0,0,0);
        acc(0,1,16'h0128,16'h0065,0,0,0);
        acc(0,1,16'h00A0,0,1,0,0);
        acc(1,1,16'h0129,16'h04D2,0,0,0);
        acc(1,0,16'h0129,0,1,0,16'h270F);
        acc(0,1,16'h0128,16'h0007,0,0,0);
        acc(0,1,16'h0128,16'h0065,1,0,0);
        w = 16'($urandom);
        acc(0,1,16'h0007,w,1,0,0);
        acc(0,1,16'h0129,16'h10E1,1,0,0);
        acc(1,1,16'h004E,1,0,1,0);
        chk(lock_active, 1);
        acc(0,0,16'h0007,0,1,0,w);
        acc(0,1,16'h03DF,16'h0005,1,0,0);
        unit_attached = 0;
        acc(0,1,16'h03DF,16'h0005,0,1,0);
        unit_attached = 1;
        acc(1,1,16'h0129,16'h10E1,1,0,0);
        acc(0,1,16'h0129,16'h10E1,1,0,0);
        for (i = 1; i < 7; i++) begin
            w = 16'h03E8 + 16'($urandom % 3000);
            {self_wr_valid, self_wr_param, self_wr_data} = {1'b1, w, ~w};
            acc(1,1,16'h0129,w,0,1,0);
            acc(1,0,16'h0129,0,1,0,i > 5 ? 5 : i);
        end
        acc(1,1,16'h0129,16'h10E1,0,1,0);
        all_clear_req = 1;
        @(negedge clk_sys) all_clear_req = 0;
        chk(store_clear, 1);
        acc(1,0,16'h0128,0,1,0,16'h270F);
        chk(lock_active, 0);
        acc(0,0,16'h00A0,0,1,0,16'h270F);
        acc(0,1,16'h00A0,0,1,0,0);
        acc(1,1,16'h0227,2,1,0,0);
        acc(0,1,16'h0128,16'h0003,1,0,0);
        acc(0,1,16'h0129,16'h1F40,1,0,0);
        acc(0,0,16'h0129,0,1,0,0);
        acc(1,1,16'h004E,1,0,1,0);
        acc(0,1,16'h0129,16'h1F40,1,0,0);
        acc(0,1,16'h00A0,16'h270F,1,0,0);
        acc(1,0,16'h0200,0,0,0,0);
        for (i = 0; i < 9; i++) begin
            acc(0,1,16'h004E,i % 3,1,0,0);
            {forward_start, reverse_start, panel_fwd, panel_rev, net_fwd, net_rev} = 6'($urandom);
            repeat (6) @(negedge clk_sys);
            f = forward_start | panel_fwd | net_fwd;
            r = reverse_start | panel_rev | net_rev;
            chk({run_fwd, run_rev}, {dir(f, r, i % 3 != 2), dir(r, f, i % 3 != 1)});
        end
        motor_running = 1;
        acc(0,1,16'h0007,1,0,0,0);
        acc(0,1,16'h004D,2,1,0,0);
        acc(0,1,16'h0007,3,1,0,0);
        acc(0,1,16'h0060,1,0,0,0);
        acc(0,1,16'h004D,1,1,0,0);
        motor_running = 0;
        acc(0,1,16'h0007,4,0,0,0);
        test_done;
    end
endmodule
bind pag_main pag_sva u_sva (.*);
